/* File: fce_pkg.sv */
// Package with codes, field positions and timing constants for the fault code lamp encoder.
package fce_pkg;
	localparam int          NUM_CH            = 8;
	localparam logic [15:0] CODE_NONE         = 16'h0000;
	localparam logic [15:0] CODE_HW_FAIL      = 16'ha600;
	localparam logic [15:0] CODE_SUPPLY       = 16'ha601;
	localparam logic [15:0] CODE_CALIB        = 16'ha603;
	localparam logic [15:0] CODE_ALARM_BASE   = 16'ha400;
	localparam logic [15:0] CODE_WARN1_BASE   = 16'ha000;
	localparam logic [15:0] CODE_WARN2_BASE   = 16'ha800;
	localparam int          ERR_CH_LSB        = 0;
	localparam int          ERR_SUPPLY_BIT    = 15;
	localparam logic [15:0] ERR_BITS_RESET    = 16'h0000;
	localparam int          CLK_MHZ           = 200;
	localparam int          BLINK_HALF_MS     = 250;
	localparam int          BLINK_HALF_CYC    = BLINK_HALF_MS * 1000 * CLK_MHZ;
	typedef enum logic [1:0] {
		FCE_ERR_OFF,
		FCE_ERR_BLINK,
		FCE_ERR_ON
	} fce_err_lamp_type;
endpackage

/* File: fce_blinker.sv */
// Free running square wave used to blink the error lamp.
`timescale 1ns/1ps
`default_nettype none
module fce_blinker #(
	parameter int HALF_CYC = fce_pkg::BLINK_HALF_CYC
) (
	input  wire logic sys_clk_in,
	input  wire logic arst_n_in,
	output var  logic phase_out
);
	logic [31:0] cnt_ff;

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			cnt_ff    <= 32'h0;
			phase_out <= 1'b0;
		end else if (cnt_ff >= 32'(HALF_CYC - 1)) begin
			cnt_ff    <= 32'h0;
			phase_out <= ~phase_out;
		end else begin
			cnt_ff <= cnt_ff + 32'h1;
		end
	end
endmodule // fce_blinker
`default_nettype wire

/* File: fce_encoder.sv */
// Fault code encoder that drives the error code, error bit field and the two lamps.
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] Hardware fail A600, supply A601, alarm lamps
// [R2] Calibration fault reports A603, alarm lamps
// [R3] Channel alarm reports A400 plus channel
// [R4] First warning A000 plus channel, blink
// [R5] Second warning A800 plus channel, lamp off
// [R6] Error bits: channels 0-7, bit 15 supply
// [R7] Error lamp on/blink/off; run lamp running
// [R8] Most severe first, low channel wins
module fce_encoder #(
	parameter int BLINK_HALF_CYC = fce_pkg::BLINK_HALF_CYC
) (
	input  wire logic        sys_clk_in,
	input  wire logic        arst_n_in,
	input  wire logic        running_in,
	input  wire logic        hw_fail_in,
	input  wire logic        supply_bad_in,
	input  wire logic        calib_bad_in,
	input  wire logic [7:0]  ch_range_in,
	input  wire logic [7:0]  ch_alarm_sel_in,
	input  wire logic [7:0]  ch_warn1_sel_in,
	output var  logic [15:0] err_code_out,
	output var  logic [15:0] err_bits_out,
	output var  logic        run_lamp_out,
	output var  logic        err_lamp_out
);
	localparam int          NCH         = fce_pkg::NUM_CH;
	localparam logic [31:0] BLINK_LIMIT = 32'(BLINK_HALF_CYC);

	logic                      blink_phase;
	logic [15:0]               nxt_code;
	fce_pkg::fce_err_lamp_type nxt_lamp;
	fce_pkg::fce_err_lamp_type lamp_ff;
	logic                      nxt_run;
	logic [7:0]                alarm_ch;
	logic [7:0]                warn1_ch;
	logic [7:0]                warn2_ch;
	logic [15:0]               nxt_bits;
	logic                      sys_fault;
	logic                      phase_seen_ff;
	logic [31:0]               blink_age_ff;

	fce_blinker #(
		.HALF_CYC (BLINK_HALF_CYC)
	) u_blink (
		.sys_clk_in (sys_clk_in),
		.arst_n_in  (arst_n_in),
		.phase_out  (blink_phase)
	);

	assign alarm_ch = ch_range_in & ch_alarm_sel_in;
	assign warn1_ch = ch_range_in & ~ch_alarm_sel_in & ch_warn1_sel_in; // [R8]
	assign warn2_ch = ch_range_in & ~ch_alarm_sel_in & ~ch_warn1_sel_in;
	assign sys_fault = hw_fail_in || supply_bad_in || calib_bad_in;

	always_comb begin
		nxt_code = fce_pkg::CODE_NONE;
		nxt_lamp = fce_pkg::FCE_ERR_OFF;
		nxt_run  = running_in;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (warn2_ch[i]) begin
				nxt_code = fce_pkg::CODE_WARN2_BASE + 16'(i); // [R5]
			end
		end
		for (int i = NCH - 1; i >= 0; i--) begin
			if (warn1_ch[i]) begin
				nxt_code = fce_pkg::CODE_WARN1_BASE + 16'(i); // [R4]
			end
		end
		if (|warn1_ch) begin
			nxt_lamp = fce_pkg::FCE_ERR_BLINK; // [R4] [R7]
		end
		for (int i = NCH - 1; i >= 0; i--) begin
			if (alarm_ch[i]) begin
				nxt_code = fce_pkg::CODE_ALARM_BASE + 16'(i); // [R3]
			end
		end
		if (calib_bad_in) begin
			nxt_code = fce_pkg::CODE_CALIB; // [R2]
		end
		if (supply_bad_in) begin
			nxt_code = fce_pkg::CODE_SUPPLY; // [R1]
		end
		if (hw_fail_in) begin
			nxt_code = fce_pkg::CODE_HW_FAIL; // [R1] [R8]
		end
		if (|alarm_ch || calib_bad_in || supply_bad_in || hw_fail_in) begin
			nxt_lamp = fce_pkg::FCE_ERR_ON; // [R1] [R2] [R3] [R7]
			nxt_run  = 1'b0;
		end
	end

	always_comb begin
		nxt_bits = fce_pkg::ERR_BITS_RESET;
		nxt_bits[fce_pkg::ERR_CH_LSB +: NCH] = ch_range_in; // [R6]
		nxt_bits[fce_pkg::ERR_SUPPLY_BIT]    = supply_bad_in; // [R6]
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			err_code_out <= fce_pkg::CODE_NONE;
			lamp_ff      <= fce_pkg::FCE_ERR_OFF;
			run_lamp_out <= 1'b0;
		end else begin
			err_code_out <= nxt_code;
			lamp_ff      <= nxt_lamp;
			run_lamp_out <= nxt_run; // [R7]
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			err_bits_out <= fce_pkg::ERR_BITS_RESET;
		end else begin
			err_bits_out <= nxt_bits;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			err_lamp_out <= 1'b0;
		end else begin
			unique case (nxt_lamp)
				fce_pkg::FCE_ERR_OFF:   err_lamp_out <= 1'b0;
				fce_pkg::FCE_ERR_BLINK: err_lamp_out <= blink_phase; // [R7]
				fce_pkg::FCE_ERR_ON:    err_lamp_out <= 1'b1;
				default:                err_lamp_out <= 1'b0;
			endcase
		end
	end

	// Counts the cycles that the blink phase has held, so that a stuck blinker is caught.
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			phase_seen_ff <= 1'b0;
			blink_age_ff  <= 32'h0;
		end else begin
			phase_seen_ff <= blink_phase;
			if (blink_phase != phase_seen_ff) begin
				blink_age_ff <= 32'h0;
			end else begin
				blink_age_ff <= blink_age_ff + 32'h1;
			end
		end
	end

	AST_HW_FAIL: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R1]
		hw_fail_in |=> (err_code_out == 16'ha600) && !run_lamp_out && err_lamp_out)
		else $error("hardware fail code or lamps wrong");
	AST_SUPPLY: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R1]
		(supply_bad_in && !hw_fail_in) |=> (err_code_out == 16'ha601) && err_lamp_out)
		else $error("supply code wrong");
	AST_CALIB: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R2]
		(calib_bad_in && !hw_fail_in && !supply_bad_in) |=> (err_code_out == 16'ha603) && !run_lamp_out)
		else $error("calibration code wrong");
	AST_ALARM0: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R3]
		(alarm_ch[0] && !hw_fail_in && !supply_bad_in && !calib_bad_in) |=> (err_code_out == 16'ha400))
		else $error("channel alarm code wrong");
	AST_ALARM7: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R8]
		(alarm_ch == 8'h80 && !hw_fail_in && !supply_bad_in && !calib_bad_in) |=> (err_code_out == 16'ha407))
		else $error("channel 7 alarm code wrong");
	AST_WARN1: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R4]
		(warn1_ch[3:0] == 4'h8 && alarm_ch == 8'h0 && !hw_fail_in && !supply_bad_in && !calib_bad_in)
		|=> (err_code_out == 16'ha003) && (run_lamp_out == $past(running_in)))
		else $error("first warning code wrong");
	AST_WARN2: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R5]
		(warn2_ch[0] && warn1_ch == 8'h0 && alarm_ch == 8'h0 && !hw_fail_in && !supply_bad_in && !calib_bad_in)
		|=> (err_code_out == 16'ha800) && !err_lamp_out)
		else $error("second warning code or lamp wrong");
	AST_BITS: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R6]
		1'b1 |=> (err_bits_out[7:0] == $past(ch_range_in)) && (err_bits_out[15] == $past(supply_bad_in)))
		else $error("error bit field wrong");
	AST_CLEAN: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R7]
		(ch_range_in == 8'h0 && !hw_fail_in && !supply_bad_in && !calib_bad_in)
		|=> (err_code_out == 16'h0000) && !err_lamp_out)
		else $error("lamp not off when normal");
	AST_SUPPLY_RUN: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R1]
		supply_bad_in |=> !run_lamp_out && err_lamp_out)
		else $error("supply fault lamps wrong");
	AST_CALIB_LAMP: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R2]
		calib_bad_in |=> err_lamp_out && !run_lamp_out)
		else $error("calibration fault lamps wrong");
	AST_ALARM_ANY: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R3]
		(|alarm_ch) |=> !run_lamp_out && err_lamp_out)
		else $error("channel alarm lamps wrong");
	AST_ALARM_CODE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R3]
		((|alarm_ch) && !sys_fault) |=> (err_code_out[15:8] == 8'ha4) && (err_code_out[7:3] == 5'h00))
		else $error("channel alarm code class wrong");
	AST_WARN1_CODE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R4]
		((|warn1_ch) && alarm_ch == 8'h0 && !sys_fault)
		|=> (err_code_out[15:8] == 8'ha0) && (err_code_out[7:3] == 5'h00))
		else $error("first warning code class wrong");
	AST_WARN1_LAMP: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R4]
		((|warn1_ch) && alarm_ch == 8'h0 && !sys_fault)
		|=> (err_lamp_out == $past(blink_phase)) && (run_lamp_out == $past(running_in)))
		else $error("first warning lamps wrong");
	AST_WARN2_CODE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R5]
		((|warn2_ch) && warn1_ch == 8'h0 && alarm_ch == 8'h0 && !sys_fault)
		|=> (err_code_out[15:8] == 8'ha8) && !err_lamp_out && (run_lamp_out == $past(running_in)))
		else $error("second warning code class or lamps wrong");
	AST_BITS_ZERO: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R6]
		1'b1 |=> (err_bits_out[14:8] == 7'h00))
		else $error("unused error bits set");
	AST_RUN_FOLLOW: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R7]
		(alarm_ch == 8'h0 && !sys_fault) |=> (run_lamp_out == $past(running_in)))
		else $error("run lamp does not follow running state");
	AST_LAMP_ON: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R7]
		(lamp_ff == fce_pkg::FCE_ERR_ON) |-> err_lamp_out)
		else $error("error lamp not steadily lit");
	AST_LAMP_OFF: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R7]
		(lamp_ff == fce_pkg::FCE_ERR_OFF) |-> !err_lamp_out)
		else $error("error lamp not off");
	AST_BLINK_AGE: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // [R7]
		blink_age_ff <= BLINK_LIMIT)
		else $error("blink phase stuck");

	COV_HW: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in) hw_fail_in ##1 err_lamp_out);
	COV_BLINK: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		(lamp_ff == fce_pkg::FCE_ERR_BLINK) && err_lamp_out);
	COV_WARN2: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in) err_code_out == 16'ha805);
	COV_SUPPLY: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		(supply_bad_in && !hw_fail_in) ##1 (err_code_out == 16'ha601));
	COV_ALARM7: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in)
		(err_code_out == 16'ha407) && !run_lamp_out);
endmodule // fce_encoder
`default_nettype wire

/* File: fce_host_model.sv */
// Host controller model that reads the reported error code each cycle.
`timescale 1ns/1ps
`default_nettype none
module fce_host_model (
	input  wire logic        sys_clk_in,
	input  wire logic        arst_n_in,
	input  wire logic [15:0] err_code_in,
	output var  logic [15:0] seen_code_out
);
	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			seen_code_out <= 16'h0000;
		end else begin
			seen_code_out <= err_code_in;
		end
	end
endmodule // fce_host_model
`default_nettype wire

/* File: tb.sv */
// Self-checking testbench for the fault code lamp encoder.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        run = 1'b1;
	logic        hw = 1'b0;
	logic        sup = 1'b0;
	logic        cal = 1'b0;
	logic [7:0]  rng = 8'h00;
	logic [7:0]  alm = 8'h00;
	logic [7:0]  w1 = 8'h00;
	logic [15:0] code, bits, host;
	logic        run_l, err_l;
	int          n_mismatch = 0;
	int          total_checks = 0;
	always #2.5 clk = ~clk;
	fce_encoder #(.BLINK_HALF_CYC(4)) dut (.sys_clk_in(clk), .arst_n_in(rst_n), .running_in(run),
		.hw_fail_in(hw), .supply_bad_in(sup), .calib_bad_in(cal), .ch_range_in(rng), .ch_alarm_sel_in(alm),
		.ch_warn1_sel_in(w1), .err_code_out(code), .err_bits_out(bits), .run_lamp_out(run_l), .err_lamp_out(err_l));
	fce_host_model host_m (.sys_clk_in(clk), .arst_n_in(rst_n), .err_code_in(code), .seen_code_out(host));
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Drives one set of conditions and waits until the encoder has answered.
	task automatic put(input logic h, input logic s, input logic c, input logic [7:0] r, a, w);
		@(posedge clk);
		hw <= h;
		sup <= s;
		cal <= c;
		rng <= r;
		alm <= a;
		w1 <= w;
		@(posedge clk);
		#1;
	endtask
	task automatic look(input logic [15:0] c, input logic rl, input logic el, input logic use_el);
		chk(code, c);
		chk({15'h0000, run_l}, {15'h0000, rl});
		if (use_el) begin
			chk({15'h0000, err_l}, {15'h0000, el});
		end
	endtask
	task automatic t_system;
		put(1'b1, 1'b1, 1'b1, 8'hff, 8'hff, 8'h00);
		look(fce_pkg::CODE_HW_FAIL, 1'b0, 1'b1, 1'b1);
		chk(bits, 16'h80ff);
		put(1'b0, 1'b1, 1'b1, 8'hff, 8'hff, 8'h00);
		look(fce_pkg::CODE_SUPPLY, 1'b0, 1'b1, 1'b1);
		put(1'b0, 1'b0, 1'b1, 8'hff, 8'hff, 8'h00);
		look(fce_pkg::CODE_CALIB, 1'b0, 1'b1, 1'b1);
		chk(bits, 16'h00ff);
	endtask
	task automatic t_chan;
		logic [7:0] r;
		for (int n = 0; n < 8; n++) begin
			r = 8'hff << n;
			put(1'b0, 1'b0, 1'b0, r, r, 8'h00);
			look(16'ha400 + 16'(n), 1'b0, 1'b1, 1'b1);
			put(1'b0, 1'b0, 1'b0, r, 8'h00, 8'h00);
			look(16'ha800 + 16'(n), 1'b1, 1'b0, 1'b1);
			chk(bits, {8'h00, r});
			put(1'b0, 1'b0, 1'b0, r, 8'h00, r);
			look(16'ha000 + 16'(n), 1'b1, 1'b0, 1'b0);
		end
		put(1'b0, 1'b0, 1'b0, 8'h81, 8'h80, 8'h01);
		look(16'ha407, 1'b0, 1'b1, 1'b1);
		@(posedge clk);
		#1;
		chk(host, 16'ha407);
	endtask
	task automatic t_blink;
		int hi;
		hi = 0;
		put(1'b0, 1'b0, 1'b0, 8'h01, 8'h00, 8'h01);
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			#1;
			hi += (err_l === 1'b1) ? 1 : 0;
		end
		chk(16'(hi), 16'h0008);
		@(posedge clk);
		run <= 1'b0;
		put(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
		look(fce_pkg::CODE_NONE, 1'b0, 1'b0, 1'b1);
	endtask
	task automatic results;
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		@(posedge clk);
		#1;
		look(fce_pkg::CODE_NONE, 1'b0, 1'b0, 1'b1);
		@(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		look(fce_pkg::CODE_NONE, 1'b1, 1'b0, 1'b1);
		t_system();
		t_chan();
		t_blink();
		results();
	end
endmodule // tb
`default_nettype wire
